// >>> stx_pkg.sv
// Shared constants and types for the skip, table-read and exclusive-or
// execution group.
// Assumes the core's fetch/decode stage hands over one decoded operation
// at a time on the same clock.
package stx_pkg;

  // ******************************************************************
  // widths
  // ******************************************************************
  localparam int unsigned DATA_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned BIT_SEL_W = 3;
  localparam int unsigned OFFSET_W = 8;
  localparam int unsigned REG_ADDR_W = 8;

  // ******************************************************************
  // register map, byte addresses
  // ******************************************************************
  localparam logic [7:0] ADDR_ACC = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TABLE_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_TABLE_PAGE = 8'h0C;
  localparam logic [7:0] ADDR_TABLE_HIGH = 8'h10;

  localparam int unsigned STATUS_ZERO_BIT = 0;
  localparam int unsigned STATUS_BUSY_BIT = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ******************************************************************
  // decoded operations and sequencer states
  // ******************************************************************
  typedef enum logic [3:0] {
    OP_NONE,
    OP_SWAP_ACC,
    OP_SKIP_ZERO,
    OP_SKIP_ZERO_COPY,
    OP_SKIP_BIT_ZERO,
    OP_TABLE_GIVEN,
    OP_TABLE_CURRENT,
    OP_TABLE_LAST,
    OP_XOR_ACC,
    OP_XOR_MEM,
    OP_XOR_IMM
  } stx_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DUMMY,
    ST_TABLE_FETCH,
    ST_TABLE_STORE
  } stx_state_t;

endpackage

// >>> stx_alu.sv
// Combinational result unit for the group: nibble swap, zero tests,
// bit test and the three exclusive-or forms.
// Assumes operands are stable in the cycle the sequencer accepts them.
`timescale 1ns/1ps
module stx_alu (
  // decoded operation
  input wire stx_pkg::stx_op_t op,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] operand,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  // results
  output logic [7:0] result,
  output logic result_zero,
  output logic skip_taken,
  output logic writes_acc,
  output logic writes_mem,
  output logic writes_zero,
  output logic is_table
);

  always_comb begin
    result = acc_in;
    skip_taken = 1'b0;
    writes_acc = 1'b0;
    writes_mem = 1'b0;
    writes_zero = 1'b0;
    is_table = 1'b0;
    case (op)
      stx_pkg::OP_SWAP_ACC: begin
        result = {operand[stx_pkg::NIB_W-1:0],
                  operand[stx_pkg::DATA_W-1:stx_pkg::NIB_W]};
        writes_acc = 1'b1;
      end
      stx_pkg::OP_SKIP_ZERO: begin
        skip_taken = (operand == stx_pkg::ZERO_BYTE);
      end
      stx_pkg::OP_SKIP_ZERO_COPY: begin
        result = operand;
        writes_acc = 1'b1;
        skip_taken = (operand == stx_pkg::ZERO_BYTE);
      end
      stx_pkg::OP_SKIP_BIT_ZERO: begin
        skip_taken = ~operand[bit_sel];
      end
      stx_pkg::OP_TABLE_GIVEN,
      stx_pkg::OP_TABLE_CURRENT,
      stx_pkg::OP_TABLE_LAST: begin
        is_table = 1'b1;
      end
      stx_pkg::OP_XOR_ACC: begin
        result = acc_in ^ operand;
        writes_acc = 1'b1;
        writes_zero = 1'b1;
      end
      stx_pkg::OP_XOR_MEM: begin
        result = acc_in ^ operand;
        writes_mem = 1'b1;
        writes_zero = 1'b1;
      end
      stx_pkg::OP_XOR_IMM: begin
        result = acc_in ^ imm;
        writes_acc = 1'b1;
        writes_zero = 1'b1;
      end
      default: begin
        result = acc_in;
      end
    endcase
  end

  assign result_zero = (result == stx_pkg::ZERO_BYTE);

endmodule // stx_alu

// >>> stx_exec.sv
// Execution sequencer for nibble swap, zero skips, table reads and
// exclusive-or, with accumulator, zero flag and table pointers.
// Assumes the core holds the data memory address steady until exec_done
// and that program memory answers one cycle after pm_rd.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module stx_exec #(
  parameter int unsigned PM_ADDR_W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // decoded instruction
  input wire logic exec_strobe,
  input wire logic [3:0] exec_op,
  input wire logic [7:0] exec_operand,
  input wire logic [2:0] exec_bit,
  input wire logic [7:0] exec_imm,
  input wire logic [PM_ADDR_W-9:0] cur_page,
  // core state and sequencing
  output logic [7:0] acc,
  output logic zero_flag,
  output logic busy,
  output logic skip_dummy,
  output logic exec_done,
  // data memory write
  output logic dm_we,
  output logic [7:0] dm_wdata,
  // program memory
  output logic pm_rd,
  output logic [PM_ADDR_W-1:0] pm_addr,
  input wire logic [15:0] pm_data,
  output logic [7:0] table_high_latch
);

  localparam int unsigned PAGE_W = PM_ADDR_W - stx_pkg::OFFSET_W;

  // ******************************************************************
  // elaboration checks
  // ******************************************************************
  // page pointer must exist and fit the 8-bit register port
  if (PM_ADDR_W <= stx_pkg::OFFSET_W || PM_ADDR_W > stx_pkg::WORD_W) begin
    $error("PM_ADDR_W must be 9 to 16");
  end

  // ******************************************************************
  // declarations
  // ******************************************************************
  stx_pkg::stx_op_t op;
  stx_pkg::stx_state_t state;
  stx_pkg::stx_state_t next_state;
  logic [7:0] table_offset_pointer;
  logic [PAGE_W-1:0] table_page_pointer;
  logic [7:0] alu_result;
  logic alu_zero;
  logic skip_taken;
  logic writes_acc;
  logic writes_mem;
  logic writes_zero;
  logic is_table;
  logic accept;
  logic [PAGE_W-1:0] next_page;

  assign op = stx_pkg::stx_op_t'(exec_op);
  // strobes during a multi-cycle operation are ignored
  assign accept = exec_strobe && (state == stx_pkg::ST_IDLE);

  stx_alu u_alu (
    .op(op),
    .acc_in(acc),
    .operand(exec_operand),
    .imm(exec_imm),
    .bit_sel(exec_bit),
    .result(alu_result),
    .result_zero(alu_zero),
    .skip_taken(skip_taken),
    .writes_acc(writes_acc),
    .writes_mem(writes_mem),
    .writes_zero(writes_zero),
    .is_table(is_table)
  );

  // ******************************************************************
  // sequencer
  // ******************************************************************
  always_comb begin
    next_state = state;
    case (state)
      stx_pkg::ST_IDLE: begin
        if (accept && is_table) begin
          next_state = stx_pkg::ST_TABLE_FETCH;
        end else if (accept && skip_taken) begin
          next_state = stx_pkg::ST_DUMMY;
        end
      end
      stx_pkg::ST_DUMMY: begin
        next_state = stx_pkg::ST_IDLE;
      end
      stx_pkg::ST_TABLE_FETCH: begin
        next_state = stx_pkg::ST_TABLE_STORE;
      end
      stx_pkg::ST_TABLE_STORE: begin
        next_state = stx_pkg::ST_IDLE;
      end
      default: begin
        next_state = stx_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= stx_pkg::ST_IDLE;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      busy <= (next_state != stx_pkg::ST_IDLE);
    end
  end

  // the dummy cycle stands in for the skipped instruction's fetch slot
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      skip_dummy <= 1'b0;
      exec_done <= 1'b0;
    end else begin
      skip_dummy <= accept && skip_taken;
      exec_done <= (accept && !is_table && !skip_taken)
                   || (state == stx_pkg::ST_DUMMY)
                   || (state == stx_pkg::ST_TABLE_STORE);
    end
  end

  // ******************************************************************
  // accumulator and zero flag
  // ******************************************************************
  // an executing instruction wins over a software write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      acc <= stx_pkg::RESET_BYTE;
    end else if (accept && writes_acc) begin
      acc <= alu_result;
    end else if (reg_wr && reg_addr == stx_pkg::ADDR_ACC) begin
      acc <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      zero_flag <= 1'b0;
    end else if (accept && writes_zero) begin
      zero_flag <= alu_zero;
    end else if (reg_wr && reg_addr == stx_pkg::ADDR_STATUS) begin
      zero_flag <= reg_wdata[stx_pkg::STATUS_ZERO_BIT];
    end
  end

  // ******************************************************************
  // table pointers and program memory access
  // ******************************************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      table_offset_pointer <= stx_pkg::RESET_BYTE;
      table_page_pointer <= '0;
    end else if (reg_wr && reg_addr == stx_pkg::ADDR_TABLE_OFFSET) begin
      table_offset_pointer <= reg_wdata;
    end else if (reg_wr && reg_addr == stx_pkg::ADDR_TABLE_PAGE) begin
      table_page_pointer <= reg_wdata[PAGE_W-1:0];
    end
  end

  always_comb begin
    if (op == stx_pkg::OP_TABLE_CURRENT) begin
      next_page = cur_page;
    end else if (op == stx_pkg::OP_TABLE_LAST) begin
      next_page = '1;
    end else begin
      next_page = table_page_pointer;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pm_rd <= 1'b0;
      pm_addr <= '0;
    end else begin
      pm_rd <= accept && is_table;
      if (accept && is_table) begin
        pm_addr <= {next_page, table_offset_pointer};
      end
    end
  end

  // program word arrives in the store state; split it there
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      table_high_latch <= stx_pkg::RESET_BYTE;
    end else if (state == stx_pkg::ST_TABLE_STORE) begin
      table_high_latch <=
        pm_data[stx_pkg::WORD_W-1:stx_pkg::DATA_W];
    end
  end

  // ******************************************************************
  // data memory write-back
  // ******************************************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dm_we <= 1'b0;
      dm_wdata <= stx_pkg::RESET_BYTE;
    end else if (state == stx_pkg::ST_TABLE_STORE) begin
      dm_we <= 1'b1;
      dm_wdata <= pm_data[stx_pkg::DATA_W-1:0];
    end else begin
      dm_we <= accept && writes_mem;
      if (accept && writes_mem) begin
        dm_wdata <= alu_result;
      end
    end
  end

  // ******************************************************************
  // register read port
  // ******************************************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= stx_pkg::RESET_BYTE;
    end else if (!reg_rd) begin
      reg_rdata <= stx_pkg::RESET_BYTE;
    end else if (reg_addr == stx_pkg::ADDR_ACC) begin
      reg_rdata <= acc;
    end else if (reg_addr == stx_pkg::ADDR_STATUS) begin
      reg_rdata <= stx_pkg::RESET_BYTE;
      reg_rdata[stx_pkg::STATUS_ZERO_BIT] <= zero_flag;
      reg_rdata[stx_pkg::STATUS_BUSY_BIT] <= busy;
    end else if (reg_addr == stx_pkg::ADDR_TABLE_OFFSET) begin
      reg_rdata <= table_offset_pointer;
    end else if (reg_addr == stx_pkg::ADDR_TABLE_PAGE) begin
      reg_rdata <= 8'(table_page_pointer);
    end else if (reg_addr == stx_pkg::ADDR_TABLE_HIGH) begin
      reg_rdata <= table_high_latch;
    end else begin
      reg_rdata <= stx_pkg::RESET_BYTE;
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  logic [7:0] h_operand;
  logic [7:0] h_acc;
  logic [7:0] h_imm;
  logic [7:0] h_offset;
  logic [PAGE_W-1:0] h_page;
  logic [PAGE_W-1:0] h_cur_page;
  logic [15:0] h_pm;

  always_ff @(posedge sys_clk) begin
    h_operand <= exec_operand;
    h_acc <= acc;
    h_imm <= exec_imm;
    h_offset <= table_offset_pointer;
    h_page <= table_page_pointer;
    h_cur_page <= cur_page;
    h_pm <= pm_data;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_swap_acc_value: assert property (
    accept && op == stx_pkg::OP_SWAP_ACC |=> acc == {h_operand[3:0],
      h_operand[7:4]} && zero_flag == $past(zero_flag) && !dm_we)
    else $error("nibble swap result wrong");

  a_skip_zero_two: assert property (
    accept && op == stx_pkg::OP_SKIP_ZERO && exec_operand == 8'h00
    |=> skip_dummy && !exec_done ##1 exec_done && !skip_dummy)
    else $error("zero skip did not take two cycles");

  a_dummy_then_done: assert property (
    skip_dummy |-> busy ##1 exec_done && !busy)
    else $error("dummy cycle not followed by completion");

  a_skip_fail_single: assert property (
    accept && !is_table && !skip_taken |=> exec_done && !skip_dummy)
    else $error("untaken skip not single cycle");

  a_copy_to_acc: assert property (
    accept && op == stx_pkg::OP_SKIP_ZERO_COPY
    |=> acc == h_operand && skip_dummy == (h_operand == 8'h00))
    else $error("copy skip wrong");

  a_bit_skip: assert property (
    accept && op == stx_pkg::OP_SKIP_BIT_ZERO
    |=> skip_dummy == !h_operand[$past(exec_bit)])
    else $error("bit skip wrong");

  a_given_page_addr: assert property (
    accept && op == stx_pkg::OP_TABLE_GIVEN
    |=> pm_rd && pm_addr == {h_page, h_offset} ##2 dm_we && exec_done
      && dm_wdata == h_pm[7:0] && table_high_latch == h_pm[15:8])
    else $error("given page table read wrong");

  a_current_page_addr: assert property (
    accept && op == stx_pkg::OP_TABLE_CURRENT
    |=> pm_rd && pm_addr == {h_cur_page, h_offset})
    else $error("current page address wrong");

  a_last_page_addr: assert property (
    accept && op == stx_pkg::OP_TABLE_LAST
    |=> pm_rd && pm_addr[PM_ADDR_W-1:stx_pkg::OFFSET_W] == '1
      && zero_flag == $past(zero_flag))
    else $error("last page address wrong");

  a_xor_acc_zero: assert property (
    accept && op == stx_pkg::OP_XOR_ACC
    |=> acc == (h_acc ^ h_operand) && zero_flag == (acc == 8'h00))
    else $error("xor to accumulator wrong");

  a_xor_mem_write: assert property (
    accept && op == stx_pkg::OP_XOR_MEM
    |=> dm_we && dm_wdata == (h_acc ^ h_operand) && acc == h_acc
      && zero_flag == (dm_wdata == 8'h00))
    else $error("xor to memory wrong");

  a_xor_imm_acc: assert property (
    accept && op == stx_pkg::OP_XOR_IMM
    |=> acc == (h_acc ^ h_imm) && zero_flag == (acc == 8'h00) && !dm_we)
    else $error("xor immediate wrong");

endmodule // stx_exec

// >>> stx_exec_tb.sv
// Self-checking bench for the skip, table-read and exclusive-or sequencer.
// Assumes the bench stands in for the core: it holds the operand byte
// until exec_done and answers program memory reads one cycle later.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  bad_count++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module stx_exec_tb;
  // ******************************************************************
  // signals
  // ******************************************************************
  typedef struct {
    logic [3:0] op; logic [7:0] acc0; logic z0; logic [7:0] opnd;
    logic [2:0] bsel; logic [7:0] imm; logic [7:0] eacc; logic ez;
    int ecyc; logic ewe; logic [7:0] ewd;
  } stx_row_t;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic exec_strobe = 1'b0;
  logic [3:0] exec_op = 4'h0;
  logic [7:0] exec_operand = 8'h00;
  logic [2:0] exec_bit = 3'h0;
  logic [7:0] exec_imm = 8'h00;
  logic [7:0] cur_page = 8'h56;
  logic [7:0] acc;
  logic zero_flag, busy, skip_dummy, exec_done, dm_we, pm_rd;
  logic [7:0] dm_wdata, table_high_latch;
  logic [15:0] pm_addr;
  logic [15:0] pm_data = 16'h0000;
  logic [15:0] pm_word = 16'hBEEF;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int ncyc;
  logic sd, we;
  logic [7:0] wd;
  logic [15:0] pa;
  stx_row_t rows [14];

  stx_exec stx_exec_i (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_strobe(exec_strobe),
    .exec_op(exec_op), .exec_operand(exec_operand), .exec_bit(exec_bit),
    .exec_imm(exec_imm), .cur_page(cur_page), .acc(acc),
    .zero_flag(zero_flag), .busy(busy), .skip_dummy(skip_dummy),
    .exec_done(exec_done), .dm_we(dm_we), .dm_wdata(dm_wdata),
    .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data),
    .table_high_latch(table_high_latch));

  always #5 sys_clk = ~sys_clk;
  // word only in the cycle after the read; otherwise a changing pattern
  always @(posedge sys_clk) pm_data <= pm_rd ? pm_word : ~pm_data;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ******************************************************************
  // tasks
  // ******************************************************************
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic run_op(input logic [3:0] op, input logic [7:0] opnd,
                        input logic [2:0] b, input logic [7:0] im);
    @(posedge sys_clk);
    exec_strobe <= 1'b1;
    exec_op <= op;
    exec_operand <= opnd;
    exec_bit <= b;
    exec_imm <= im;
    @(posedge sys_clk);
    exec_strobe <= 1'b0;
    ncyc = 1;
    sd = 1'b0;
    we = 1'b0;
    wd = 8'h00;
    pa = 16'h0000;
    #1;
    while (exec_done !== 1'b1 && ncyc < 10) begin
      if (skip_dummy === 1'b1) sd = 1'b1;
      if (pm_rd === 1'b1) pa = pm_addr;
      @(posedge sys_clk);
      ncyc++;
      #1;
    end
    if (dm_we === 1'b1) begin
      we = 1'b1;
      wd = dm_wdata;
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin : main
    logic [7:0] rd;
    logic [15:0] epa;
    rows = '{
      '{4'h1, 8'h11, 1'b1, 8'hA5, 3'h0, 8'h00, 8'h5A, 1'b1, 1, 1'b0, 8'h00},
      '{4'h2, 8'h33, 1'b0, 8'h00, 3'h0, 8'h00, 8'h33, 1'b0, 2, 1'b0, 8'h00},
      '{4'h2, 8'h33, 1'b1, 8'h01, 3'h0, 8'h00, 8'h33, 1'b1, 1, 1'b0, 8'h00},
      '{4'h3, 8'h77, 1'b0, 8'h00, 3'h0, 8'h00, 8'h00, 1'b0, 2, 1'b0, 8'h00},
      '{4'h3, 8'h00, 1'b1, 8'h80, 3'h0, 8'h00, 8'h80, 1'b1, 1, 1'b0, 8'h00},
      '{4'h4, 8'h44, 1'b0, 8'hF7, 3'h3, 8'h00, 8'h44, 1'b0, 2, 1'b0, 8'h00},
      '{4'h4, 8'h44, 1'b0, 8'h80, 3'h7, 8'h00, 8'h44, 1'b0, 1, 1'b0, 8'h00},
      '{4'h8, 8'h5A, 1'b0, 8'h5A, 3'h0, 8'hFF, 8'h00, 1'b1, 1, 1'b0, 8'h00},
      '{4'h8, 8'h0F, 1'b1, 8'hF0, 3'h0, 8'h00, 8'hFF, 1'b0, 1, 1'b0, 8'h00},
      '{4'h9, 8'h3C, 1'b0, 8'h3C, 3'h0, 8'h00, 8'h3C, 1'b1, 1, 1'b1, 8'h00},
      '{4'hA, 8'h81, 1'b0, 8'h00, 3'h0, 8'h81, 8'h00, 1'b1, 1, 1'b0, 8'h00},
      '{4'h0, 8'h66, 1'b1, 8'h00, 3'h0, 8'h00, 8'h66, 1'b1, 1, 1'b0, 8'h00},
      '{4'hB, 8'h27, 1'b0, 8'h00, 3'h0, 8'h00, 8'h27, 1'b0, 1, 1'b0, 8'h00},
      '{4'h9, 8'h0F, 1'b1, 8'h0A, 3'h0, 8'h00, 8'h0F, 1'b0, 1, 1'b1, 8'h05}};
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK("acc after reset", 8'h00, acc)
    `CHK("busy after reset", 1'b0, busy)
    $display("test reset done");

    // ordinary cases
    foreach (rows[i]) begin
      reg_write(stx_pkg::ADDR_ACC, rows[i].acc0);
      reg_write(stx_pkg::ADDR_STATUS, {7'h00, rows[i].z0});
      run_op(rows[i].op, rows[i].opnd, rows[i].bsel, rows[i].imm);
      @(posedge sys_clk);
      #1;
      `CHK("acc", rows[i].eacc, acc)
      `CHK("zero", rows[i].ez, zero_flag)
      `CHK("cycles", rows[i].ecyc, ncyc)
      `CHK("dummy", rows[i].ecyc == 2, sd)
      `CHK("dm_we", rows[i].ewe, we)
      `CHK("dm_wdata", rows[i].ewd, wd)
      $display("test row %0d done", i);
    end

    // table reads of all three kinds, flags and acc left alone
    reg_write(stx_pkg::ADDR_TABLE_OFFSET, 8'h34);
    reg_write(stx_pkg::ADDR_TABLE_PAGE, 8'h12);
    reg_write(stx_pkg::ADDR_ACC, 8'hC3);
    reg_write(stx_pkg::ADDR_STATUS, 8'h01);
    for (int k = 0; k < 3; k++) begin
      epa = (k == 0) ? 16'h1234 : (k == 1) ? 16'h5634 : 16'hFF34;
      pm_word = 16'hBEEF ^ {k[7:0], k[7:0]};
      run_op(4'h5 + k[3:0], 8'h00, 3'h0, 8'h00);
      `CHK("pm_addr", epa, pa)
      `CHK("cycles", 3, ncyc)
      `CHK("table low", pm_word[7:0], wd)
      @(posedge sys_clk);
      #1;
      `CHK("high latch", pm_word[15:8], table_high_latch)
      `CHK("zero kept", 1'b1, zero_flag)
      `CHK("acc kept", 8'hC3, acc)
      reg_read(stx_pkg::ADDR_TABLE_HIGH, rd);
      `CHK("high latch reg", pm_word[15:8], rd)
      $display("test table %0d done", k);
    end

    // read-only latch and unmapped address
    reg_write(stx_pkg::ADDR_TABLE_HIGH, 8'h00);
    reg_read(stx_pkg::ADDR_TABLE_HIGH, rd);
    `CHK("latch read only", pm_word[15:8], rd)
    reg_write(8'h14, 8'hAA);
    reg_read(8'h14, rd);
    `CHK("unmapped", 8'h00, rd)
    reg_read(stx_pkg::ADDR_TABLE_OFFSET, rd);
    `CHK("offset reg", 8'h34, rd)
    reg_read(stx_pkg::ADDR_TABLE_PAGE, rd);
    `CHK("page reg", 8'h12, rd)
    reg_read(stx_pkg::ADDR_STATUS, rd);
    `CHK("status reg", 8'h01, rd)
    $display("test registers done");

    // strobe while busy is ignored; busy shows in status
    @(posedge sys_clk);
    exec_strobe <= 1'b1;
    exec_op <= 4'h7;
    @(posedge sys_clk);
    exec_op <= 4'hA;
    exec_imm <= 8'hFF;
    reg_rd <= 1'b1;
    reg_addr <= stx_pkg::ADDR_STATUS;
    @(posedge sys_clk);
    exec_strobe <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    `CHK("busy", 1'b1, busy)
    `CHK("status busy", 8'h03, reg_rdata)
    @(posedge sys_clk);
    #1;
    `CHK("done", 1'b1, exec_done)
    `CHK("refused", 8'hC3, acc)
    $display("test busy done");

    // reset in mid-run clears state
    reg_write(stx_pkg::ADDR_ACC, 8'h5A);
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    `CHK("acc reset", 8'h00, acc)
    `CHK("zero reset", 1'b0, zero_flag)
    `CHK("latch reset", 8'h00, table_high_latch)
    @(posedge sys_clk);
    #1;
    `CHK("busy reset", 1'b0, busy)
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule // stx_exec_tb
